// ==== verification/test_tss_readout.sv ====
// Self-checking bench for the serial readout core.
// Drives the converter side; the host model frames the serial traffic.
`timescale 1ns/1ps
`include "tss_defs.vh"
module test_tss_readout;
    logic        clk_sys_in;
    logic        reset_in;
    logic        clk_en;
    logic        cs_n;
    logic        sck;
    logic        line;
    logic        sio_out;
    logic        sio_oe_out;
    logic [13:0] sample_in;
    logic        sample_done_in;
    logic        conv_run_out;
    logic        shutdown_out;
    logic        result_valid_out;
    logic [15:0] w;
    int          error_cnt;
    int          n_compared;
    wire  [15:0] mode = {13'h0, conv_run_out, shutdown_out, result_valid_out};
    tss_readout tss_readout_inst
    (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_en_in(clk_en), .cs_n_in(cs_n),
        .serial_clock_pin_in(sck), .sio_in(line), .sio_out(sio_out), .sio_oe_out(sio_oe_out),
        .sample_in(sample_in), .sample_done_in(sample_done_in), .conv_run_out(conv_run_out),
        .shutdown_out(shutdown_out), .result_valid_out(result_valid_out)
    );
    tss_host_model tss_host_model_inst
    (
        .clk_in(clk_sys_in), .sio_oe_in(sio_oe_out), .sio_dev_in(sio_out),
        .cs_n_out(cs_n), .sck_out(sck), .sio_line_out(line)
    );
    initial
    begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    function logic [15:0] exp_word(input logic [13:0] t);
        return {t, 2'b11};
    endfunction
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task conv(input logic [13:0] t);
        @(posedge clk_sys_in);
        sample_in <= t;
        sample_done_in <= 1'b1;
        @(posedge clk_sys_in) sample_done_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
    endtask
    task rd(input logic [15:0] cmd, input int n);
        tss_host_model_inst.frame(cmd, n, w);
    endtask
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        logic [13:0] corner [4];
        logic [13:0] t;
        int          i;
        reset_in = 1'b1;
        clk_en = 1'b1;
        corner = '{14'h0000, 14'h0001, 14'h12C0, 14'h3FFF};
        sample_in = 14'h0000;
        sample_done_in = 1'b0;
        error_cnt = 0;
        n_compared = 0;
        void'($urandom(32'h7B0B));
        repeat (20) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        chk("modes", 16'h0004, mode);
        rd(16'h0000, 16);
        chk("word", 16'h0003, w);
        $display("test power-up done");
        for (i = 0; i < 12; i++)
        begin
            t = (i < 4) ? corner[i] : 14'($urandom);
            conv(t);
            rd(16'h0000, 16);
            chk("word", exp_word(t), w);
        end
        chk("modes", 16'h0005, mode);
        @(posedge clk_sys_in) clk_en <= 1'b0;
        conv(14'h0AAA);
        clk_en <= 1'b1;
        fork
            rd(16'h0000, 16);
            begin
                repeat (30) @(posedge clk_sys_in);
                conv(14'h1555);
            end
        join
        chk("word", exp_word(t), w);
        t = 14'h1555;
        rd(16'h0000, 16);
        chk("word", exp_word(t), w);
        $display("test encoding done");
        rd({8'($urandom), 8'hFF}, 32);
        chk("word", exp_word(t), w);
        chk("modes", 16'h0002, mode);
        conv(14'h0155);
        rd(16'h005A, 32);
        chk("word", `TSS_ID_WORD, w);
        chk("modes", 16'h0002, mode);
        rd(16'h0000, 8);
        chk("word", `TSS_ID_WORD & 16'hFF00, w);
        chk("modes", 16'h0002, mode);
        rd(16'hFF00, 32);
        chk("modes", 16'h0005, mode);
        rd(16'hFFFF, 20);
        chk("word", exp_word(t), w);
        chk("modes", 16'h0005, mode);
        $display("test shutdown done");
        rd(16'h00FF, 32);
        @(posedge clk_sys_in) reset_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        chk("modes", 16'h0004, mode);
        rd(16'h0000, 16);
        chk("word", 16'h0003, w);
        $display("test mid-run reset done");
        summarize;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        error_cnt++;
        $display("unexpected run length expected done seen hang");
        summarize;
    end
endmodule // test_tss_readout

// ==== verification/tss_host_model.sv ====
// Serial host model: opens frames, reads the word, shifts a command.
// Assumes clk_in is the system clock; each SCK half lasts 3 clk.
`timescale 1ns/1ps
module tss_host_model
(
    input  wire logic clk_in,
    input  wire logic sio_oe_in,
    input  wire logic sio_dev_in,
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      sio_line_out
);
    logic drv;
    logic own;
    // Undriven line shows the host level while the host owns it, else the inverse of that level
    assign sio_line_out = sio_oe_in ? sio_dev_in : (own ? drv : ~drv);
    initial
    begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        drv = 1'b0;
        own = 1'b0;
    end
    task half;
        repeat (3) @(posedge clk_in);
    endtask
    task frame(input logic [15:0] cmd, input int n, output logic [15:0] word);
        int i;
        word = 16'h0000;
        @(posedge clk_in) cs_n_out <= 1'b0;
        half;
        for (i = 0; i < n; i++)
        begin
            if (i >= 16)
            begin
                own <= 1'b1;
                drv <= cmd[31-i];
            end
            half;
            sck_out <= 1'b1;
            if (i < 16)
                word[15-i] = sio_line_out;
            half;
            sck_out <= 1'b0;
        end
        half;
        cs_n_out <= 1'b1;
        own <= 1'b0;
        half;
        half;
    endtask
endmodule // tss_host_model

// ==== verification/tss_readout_monitor.sv ====
// Port checker for the serial readout core.
// Assumes clk_en_in drops only between frames; bound to every core instance.
`timescale 1ns/1ps
`include "tss_defs.vh"
module tss_readout_monitor
(
    input wire logic                   clk_sys_in,
    input wire logic                   reset_in,
    input wire logic                   clk_en_in,
    input wire logic                   cs_n_in,
    input wire logic                   serial_clock_pin_in,
    input wire logic                   sio_in,
    input wire logic                   sio_out,
    input wire logic                   sio_oe_out,
    input wire logic [`TSS_TEMP_W-1:0] sample_in,
    input wire logic                   sample_done_in,
    input wire logic                   conv_run_out,
    input wire logic                   shutdown_out,
    input wire logic                   result_valid_out
);
    localparam logic [15:0] ID = `TSS_ID_WORD;
    logic       sck_q;
    logic [4:0] rise_q;
    // Counts SCK rises while the core drives the line
    always @(posedge clk_sys_in or posedge reset_in)
        if (reset_in)
        begin
            sck_q <= 1'b0;
            rise_q <= 5'h00;
        end
        else
        begin
            sck_q <= serial_clock_pin_in;
            if (!sio_oe_out)
                rise_q <= 5'h00;
            else if (serial_clock_pin_in && !sck_q)
                rise_q <= rise_q + 5'h01;
        end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    a_reset_mode: assert property ($fell(reset_in) |-> conv_run_out && !shutdown_out && !result_valid_out)
        else $error("mode not default after reset");
    a_idle_release: assert property ($past(cs_n_in) && cs_n_in |-> !sio_oe_out)
        else $error("line driven while deselected");
    a_open_drive: assert property ($fell(cs_n_in) |=> sio_oe_out)
        else $error("line not driven after select");
    a_id_first: assert property ($fell(cs_n_in) && shutdown_out |=> sio_out == ID[15])
        else $error("first bit in shutdown not id");
    a_mode_excl: assert property (conv_run_out != shutdown_out)
        else $error("run and shutdown disagree");
    a_mode_change: assert property ($changed(shutdown_out) |-> $past(cs_n_in) && $past(cs_n_in, 2))
        else $error("mode changed inside a frame");
    a_out_timing: assert property (sio_oe_out && $past(sio_oe_out) && $changed(sio_out)
        |-> !$past(serial_clock_pin_in) && $past(serial_clock_pin_in, 2))
        else $error("data changed off a falling edge");
    a_tx_length: assert property (sio_oe_out |-> rise_q <= 5'h10)
        else $error("driven past 16 clocks");
    a_valid_keep: assert property ($fell(result_valid_out) |-> ##[0:1] shutdown_out)
        else $error("valid result lost");
endmodule // tss_readout_monitor
bind tss_readout tss_readout_monitor tss_readout_monitor_inst
(
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_en_in(clk_en_in), .cs_n_in(cs_n_in),
    .serial_clock_pin_in(serial_clock_pin_in), .sio_in(sio_in), .sio_out(sio_out),
    .sio_oe_out(sio_oe_out), .sample_in(sample_in), .sample_done_in(sample_done_in),
    .conv_run_out(conv_run_out), .shutdown_out(shutdown_out), .result_valid_out(result_valid_out)
);

// ==== verilog/tss_defs.vh ====
// Constants for the temperature sensor serial readout.
// Included by the readout core and its result store.
`ifndef TSS_DEFS_VH
`define TSS_DEFS_VH

// Output word layout
`define TSS_WORD_W        16
`define TSS_TEMP_W        14
`define TSS_TEMP_LO       2
`define TSS_TEMP_HI       15
`define TSS_FILL_ONES     2'h3

// Arbitrary neutral identification word, low two bits forced to ones
`define TSS_ID_WORD       16'h5A5B

// Receive phase commands
`define TSS_RX_W          8
`define TSS_CMD_RUN       8'h00
`define TSS_CMD_SHDN      8'hFF

// Serial frame counting
`define TSS_CNT_W         6
`define TSS_TX_BITS       6'h10
`define TSS_FRAME_BITS    6'h20
`define TSS_RX_MIN        4'h8
`define TSS_RX_CNT_W      4

// Host spacing between reads, kept for reference by the host side
`define TSS_CONV_TIME_MS  228

`endif

// ==== verilog/tss_readout.v ====
// Serial readout core of a temperature sensor.
// Assumes a converter outside supplies 14-bit results with a done pulse,
// and that chip select, serial clock and data in are synchronous to clk.
`timescale 1ns/1ps
`include "tss_defs.vh"

module tss_readout
(
    input  wire                    clk_sys_in,
    input  wire                    reset_in,
    input  wire                    clk_en_in,
    input  wire                    cs_n_in,
    input  wire                    serial_clock_pin_in,
    input  wire                    sio_in,
    output reg                     sio_out,
    output reg                     sio_oe_out,
    input  wire [`TSS_TEMP_W-1:0]  sample_in,
    input  wire                    sample_done_in,
    output reg                     conv_run_out,
    output reg                     shutdown_out,
    output reg                     result_valid_out
);

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_TX   = 2'b01;
    localparam [1:0] ST_RX   = 2'b10;
    // Fixed identification word; its value is arbitrary
    localparam [`TSS_WORD_W-1:0] ID_WORD = `TSS_ID_WORD;

    reg  [1:0]                   state_q;
    reg  [1:0]                   state_d;
    reg                          sck_q;
    reg                          cs_n_q;
    reg  [`TSS_WORD_W-1:0]       tx_q;
    reg  [`TSS_CNT_W-1:0]        cnt_q;
    reg  [`TSS_RX_W-1:0]         rx_q;
    reg  [`TSS_RX_CNT_W-1:0]     rx_cnt_q;
    reg                          shdn_q;
    wire [`TSS_TEMP_W-1:0]       result;
    wire                         result_valid;
    wire                         sck_rise;
    wire                         sck_fall;
    wire                         frame_start;
    wire                         frame_end;

    // Builds the output word from a temperature
    function [`TSS_WORD_W-1:0] temp_word;
        input [`TSS_TEMP_W-1:0] t;
        begin
            temp_word = {t, `TSS_FILL_ONES};
        end
    endfunction

    // Edges against previous sample; reset values match idle levels, so no false edge
    assign sck_rise    = serial_clock_pin_in & ~sck_q;
    assign sck_fall    = ~serial_clock_pin_in & sck_q;
    assign frame_start = ~cs_n_in & cs_n_q;
    assign frame_end   = cs_n_in & ~cs_n_q;

    // Result frozen while chip select is low, so a word never tears mid-read
    tss_result_store u_store
    (
        .clk_sys_in  (clk_sys_in),
        .reset_in    (reset_in),
        .clk_en_in   (clk_en_in),
        .wr_en_in    (sample_done_in & ~shdn_q),
        .wr_data_in  (sample_in),
        .hold_in     (~cs_n_in),
        .rd_data_out (result),
        .valid_out   (result_valid)
    );

    // Frame phase sequencing: transmit ends on the sixteenth rise,
    // receive runs until chip select rises
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (frame_start)
                    state_d = ST_TX;
            end
            ST_TX:
            begin
                if (cs_n_in)
                    state_d = ST_IDLE;
                else if (sck_rise && cnt_q == `TSS_TX_BITS - 6'h01)
                    state_d = ST_RX;
            end
            ST_RX:
            begin
                if (cs_n_in)
                    state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_q          <= ST_IDLE;
            sck_q            <= 1'b0;
            cs_n_q           <= 1'b1;
            tx_q             <= {`TSS_WORD_W{1'b0}};
            cnt_q            <= {`TSS_CNT_W{1'b0}};
            rx_q             <= {`TSS_RX_W{1'b0}};
            rx_cnt_q         <= {`TSS_RX_CNT_W{1'b0}};
            shdn_q           <= 1'b0;
            sio_out          <= 1'b0;
            sio_oe_out       <= 1'b0;
            conv_run_out     <= 1'b1;
            shutdown_out     <= 1'b0;
            result_valid_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            state_q          <= state_d;
            sck_q            <= serial_clock_pin_in;
            cs_n_q           <= cs_n_in;
            conv_run_out     <= ~shdn_q;
            shutdown_out     <= shdn_q;
            // Shutdown hides the result but keeps it for the return to run
            result_valid_out <= result_valid & ~shdn_q;
            case (state_q)
                ST_IDLE:
                begin
                    sio_oe_out <= 1'b0;
                    if (frame_start)
                    begin
                        // First bit appears as soon as the frame opens
                        if (shdn_q)
                        begin
                            tx_q    <= ID_WORD << 1;
                            sio_out <= ID_WORD[`TSS_TEMP_HI];
                        end
                        else
                        begin
                            tx_q    <= temp_word(result) << 1;
                            sio_out <= result[`TSS_TEMP_W-1];
                        end
                        sio_oe_out <= 1'b1;
                        cnt_q      <= {`TSS_CNT_W{1'b0}};
                        rx_cnt_q   <= {`TSS_RX_CNT_W{1'b0}};
                    end
                end
                ST_TX:
                begin
                    // Early close drops the line and leaves the mode alone
                    if (cs_n_in)
                        sio_oe_out <= 1'b0;
                    else
                    begin
                        // Next bit goes out on each fall; the host samples on the rise
                        if (sck_fall)
                        begin
                            sio_out <= tx_q[`TSS_WORD_W-1];
                            tx_q    <= tx_q << 1;
                        end
                        if (sck_rise)
                        begin
                            cnt_q <= cnt_q + 6'h01;
                            if (cnt_q == `TSS_TX_BITS - 6'h01)
                                sio_oe_out <= 1'b0;
                        end
                    end
                end
                ST_RX:
                begin
                    sio_oe_out <= 1'b0;
                    // Mode applies at frame close; fewer than eight bits change nothing
                    if (frame_end)
                    begin
                        // Codes other than run and shutdown are ignored
                        if (rx_cnt_q >= `TSS_RX_MIN)
                        begin
                            if (rx_q == `TSS_CMD_RUN)
                                shdn_q <= 1'b0;
                            else if (rx_q == `TSS_CMD_SHDN)
                                shdn_q <= 1'b1;
                        end
                    end
                    // Bits past the thirty-second rise are ignored
                    else if (sck_rise && cnt_q < `TSS_FRAME_BITS)
                    begin
                        rx_q  <= {rx_q[`TSS_RX_W-2:0], sio_in};
                        cnt_q <= cnt_q + 6'h01;
                        if (rx_cnt_q < `TSS_RX_MIN)
                            rx_cnt_q <= rx_cnt_q + 4'h1;
                    end
                end
                default:
                begin
                    sio_oe_out <= 1'b0;
                end
            endcase
        end
    end

endmodule // tss_readout

// ==== verilog/tss_result_store.v ====
// Holds the latest completed conversion result and its valid flag.
// Assumes the core raises hold_in while a serial frame is open.
`timescale 1ns/1ps
`include "tss_defs.vh"

module tss_result_store
(
    input  wire                       clk_sys_in,
    input  wire                       reset_in,
    input  wire                       clk_en_in,
    input  wire                       wr_en_in,
    input  wire [`TSS_TEMP_W-1:0]     wr_data_in,
    input  wire                       hold_in,
    output reg  [`TSS_TEMP_W-1:0]     rd_data_out,
    output reg                        valid_out
);

    reg [`TSS_TEMP_W-1:0] pend_q;
    reg                   pend_valid_q;

    always @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rd_data_out  <= {`TSS_TEMP_W{1'b0}};
            valid_out    <= 1'b0;
            pend_q       <= {`TSS_TEMP_W{1'b0}};
            pend_valid_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            // Results are parked while a frame reads the old one
            if (hold_in)
            begin
                if (wr_en_in)
                begin
                    pend_q       <= wr_data_in;
                    pend_valid_q <= 1'b1;
                end
            end
            else if (wr_en_in)
            begin
                rd_data_out  <= wr_data_in;
                valid_out    <= 1'b1;
                pend_valid_q <= 1'b0;
            end
            else if (pend_valid_q)
            begin
                rd_data_out  <= pend_q;
                valid_out    <= 1'b1;
                pend_valid_q <= 1'b0;
            end
        end
    end

endmodule // tss_result_store
